// [logic/ums_pkg.sv]
// package: constants and carrier types of the uart mode status view
// Functional notes
// - read-only five-bit status, chosen by three-bit selector
// - view 000 gives noise, 0, 0, newframe, mpbit
// - view 001 gives noise then four zeros
// - view 010 gives noise and break duration
// - view 100 gives waiting, collision, address class
// - view 101 gives waiting, null, nonnull, hit, mark
// - new frame set on first byte, read clears
// - last multiprocessor bit held, read clears
// - noise flag set on sample mismatch
// - break duration held, saturates at fifteen
// - address class codes 001 010 100 101
// - waiting and collision mirror status zero
// - null start flag cleared at frame end
// - nonnull start flag cleared at frame end
// - slave hit flag cleared at frame end
// - mark-break bit follows line condition
// - selector in bits 7 to 5 chooses view
// - byte waiting set on receive, read clears
package ums_pkg;
   // ==========================================
   // register map
   localparam logic [1:0] ADDR_MODE = 2'h0;
   localparam logic [1:0] ADDR_IRQ_STAT = 2'h1;
   localparam logic [1:0] ADDR_IRQ_MASK = 2'h2;
   localparam logic [1:0] ADDR_RXDATA = 2'h3;
   localparam int SEL_LSB = 5;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // ==========================================
   // views
   localparam logic [2:0] VIEW_MP = 3'h0;
   localparam logic [2:0] VIEW_NOISE = 3'h1;
   localparam logic [2:0] VIEW_LIN = 3'h2;
   localparam logic [2:0] VIEW_DALI = 3'h4;
   localparam logic [2:0] VIEW_DMX = 3'h5;
   localparam logic [3:0] BREAK_MAX = 4'hF;
   localparam logic [2:0] ADDR_SHORT = 3'h1;
   localparam logic [2:0] ADDR_GROUP = 3'h2;
   localparam logic [2:0] ADDR_BCAST = 3'h4;
   localparam logic [2:0] ADDR_SPECIAL = 3'h5;
   // ==========================================
   // receiver event carrier
   typedef struct packed {
      logic byteDone;      // byte landed in data register
      logic [7:0] byteData; // received byte
      logic firstOfFrame;  // byte starts a frame
      logic mpBit;         // multiprocessor bit of byte
      logic noiseHit;      // filter sample mismatch
      logic breakTick;     // one bit time of break elapsed
      logic breakEnd;      // break over
      logic collision;     // dali collision
      logic addrValid;     // address class known
      logic [2:0] addrCode; // address class code
      logic nullStart;     // dmx null start code
      logic nonNullStart;  // dmx other start code
      logic slaveHit;      // dmx slave address match
      logic frameEnd;      // frame reception over
   } ums_rx_type;
endpackage

// [logic/ums_mode_status.sv]
// module: uart mode status view with register port and interrupt
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module ums_mode_status (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // register port
   input wire logic [1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // receiver events
   input wire ums_pkg::ums_rx_type rxEvt,
   // mark-break line condition, asynchronous
   input wire logic markBreakPin,
   // interrupt
   output logic irq
);
   // ==========================================
   // state
   logic [2:0] viewSel_q;     // selector
   logic newFrame_q;          // new frame flag
   logic mpBit_q;             // last multiprocessor bit
   logic noise_q;             // noise event
   logic [3:0] brkCnt_q;      // running break count
   logic [3:0] brkDur_q;      // held break duration
   logic waiting_q;           // byte waiting
   logic [7:0] rxData_q;      // receive data
   logic collision_q;         // collision flag
   logic [2:0] addrClass_q;   // address class
   logic nullSt_q;            // null start seen
   logic nonNullSt_q;         // nonnull start seen
   logic slvHit_q;            // slave address hit
   logic [2:0] mbSync_q;      // mark-break synchroniser
   logic markBreak_q;         // filtered mark-break
   logic [4:0] irqStat_q;     // sticky events
   logic [4:0] irqMask_q;     // interrupt mask
   logic [7:0] regRdata_q;    // read data
   logic irq_q;               // interrupt level
   logic [4:0] mode_status_field;      // muxed status field
   logic rdData;              // data register read
   logic rdStat;              // status register read
   logic [4:0] irqEvt;        // event pulses
   logic [4:0] irqStat_d; // next sticky events
   logic [4:0] irqMask_d; // next interrupt mask

   assign rdData = regRd && (regAddr == ums_pkg::ADDR_RXDATA);
   assign rdStat = regRd && (regAddr == ums_pkg::ADDR_IRQ_STAT);
   assign irqEvt = {rxEvt.byteDone, rxEvt.breakEnd, rxEvt.collision,
                    rxEvt.noiseHit, rxEvt.frameEnd};

   // ==========================================
   // selector write
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         viewSel_q <= 3'h0;
      end else if (regWr && regAddr == ums_pkg::ADDR_MODE) begin
         viewSel_q <= regWdata[7:ums_pkg::SEL_LSB];
      end
   end

   // ==========================================
   // data register and byte waiting; set wins over read
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         waiting_q <= 1'b0;
         rxData_q <= ums_pkg::RESET_BYTE;
      end else if (rxEvt.byteDone) begin
         waiting_q <= 1'b1;
         rxData_q <= rxEvt.byteData;
      end else if (rdData) begin
         waiting_q <= 1'b0;
      end
   end

   // ==========================================
   // new frame and multiprocessor bit
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         newFrame_q <= 1'b0;
         mpBit_q <= 1'b0;
      end else if (rxEvt.byteDone) begin
         newFrame_q <= rxEvt.firstOfFrame;
         mpBit_q <= rxEvt.mpBit;
      end else if (rdData) begin
         newFrame_q <= 1'b0;
         mpBit_q <= 1'b0;
      end
   end

   // ==========================================
   // noise event, cleared by data read, set wins
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         noise_q <= 1'b0;
      end else if (rxEvt.noiseHit) begin
         noise_q <= 1'b1;
      end else if (rdData) begin
         noise_q <= 1'b0;
      end
   end

   // ==========================================
   // break length, saturating
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         brkCnt_q <= 4'h0;
         brkDur_q <= 4'h0;
      end else if (rxEvt.breakEnd) begin
         brkDur_q <= brkCnt_q;
         brkCnt_q <= 4'h0;
      end else if (rxEvt.breakTick && brkCnt_q != ums_pkg::BREAK_MAX) begin
         brkCnt_q <= brkCnt_q + 4'h1;
      end
   end

   // ==========================================
   // dali collision and address class
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         collision_q <= 1'b0;
         addrClass_q <= 3'h0;
      end else begin
         if (rxEvt.collision) begin
            collision_q <= 1'b1;
         end else if (rdData) begin
            collision_q <= 1'b0;
         end
         if (rxEvt.addrValid) begin
            case (rxEvt.addrCode)
               ums_pkg::ADDR_SHORT,
               ums_pkg::ADDR_GROUP,
               ums_pkg::ADDR_BCAST: addrClass_q <= rxEvt.addrCode;
               default: addrClass_q <= ums_pkg::ADDR_SPECIAL;
            endcase
         end
      end
   end

   // ==========================================
   // dmx frame flags; detection wins over frame end
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         nullSt_q <= 1'b0;
         nonNullSt_q <= 1'b0;
         slvHit_q <= 1'b0;
      end else begin
         if (rxEvt.nullStart) begin
            nullSt_q <= 1'b1;
         end else if (rxEvt.frameEnd) begin
            nullSt_q <= 1'b0;
         end
         if (rxEvt.nonNullStart) begin
            nonNullSt_q <= 1'b1;
         end else if (rxEvt.frameEnd) begin
            nonNullSt_q <= 1'b0;
         end
         if (rxEvt.slaveHit) begin
            slvHit_q <= 1'b1;
         end else if (rxEvt.frameEnd) begin
            slvHit_q <= 1'b0;
         end
      end
   end

   // ==========================================
   // mark-break synchroniser, change taken when stages 2 and 3 agree
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         mbSync_q <= 3'h0;
         markBreak_q <= 1'b0;
      end else begin
         mbSync_q <= {mbSync_q[1:0], markBreakPin};
         if (mbSync_q[1] == mbSync_q[2]) begin
            markBreak_q <= mbSync_q[2];
         end
      end
   end

   // ==========================================
   // view multiplexer
   always_comb begin
      case (viewSel_q)
         ums_pkg::VIEW_MP:
            mode_status_field = {noise_q, 2'h0, newFrame_q, mpBit_q};
         ums_pkg::VIEW_NOISE:
            mode_status_field = {noise_q, 4'h0};
         ums_pkg::VIEW_LIN:
            mode_status_field = {noise_q, brkDur_q};
         ums_pkg::VIEW_DALI:
            mode_status_field = {waiting_q, collision_q, addrClass_q};
         ums_pkg::VIEW_DMX:
            mode_status_field = {waiting_q, nullSt_q, nonNullSt_q, slvHit_q,
                        markBreak_q};
         default:
            mode_status_field = 5'h00;
      endcase
   end

   // ==========================================
   // interrupt next state; a new event beats a clearing read, and
   // the level uses the next mask so that a mask write takes effect
   // on the same edge as the status bits it covers
   always_comb begin
      irqStat_d = rdStat ? 5'h00 : irqStat_q; // read clears
      irqStat_d = irqStat_d | irqEvt; // set wins
      irqMask_d = irqMask_q; // hold by default
      if (regWr && regAddr == ums_pkg::ADDR_IRQ_MASK) begin
         irqMask_d = regWdata[4:0]; // mask write
      end
   end

   // interrupt status, mask and level registers
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         irqStat_q <= 5'h00;
         irqMask_q <= 5'h00;
         irq_q <= 1'b0;
      end else begin
         irqStat_q <= irqStat_d;
         irqMask_q <= irqMask_d;
         irq_q <= |(irqStat_d & irqMask_d); // level of unmasked bits
      end
   end

   // ==========================================
   // read data, one cycle after read strobe, zero otherwise
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         regRdata_q <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            ums_pkg::ADDR_MODE: regRdata_q <= {viewSel_q, mode_status_field};
            ums_pkg::ADDR_IRQ_STAT: regRdata_q <= {3'h0, irqStat_q};
            ums_pkg::ADDR_IRQ_MASK: regRdata_q <= {3'h0, irqMask_q};
            ums_pkg::ADDR_RXDATA: regRdata_q <= rxData_q;
            default: regRdata_q <= 8'h00;
         endcase
      end else begin
         regRdata_q <= 8'h00;
      end
   end

   assign regRdata = regRdata_q;
   assign irq = irq_q;

   // ==========================================
   // checks
   a_reserved_zero: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (viewSel_q == 3'h3 || viewSel_q[2:1] == 2'h3) |-> mode_status_field == 5'h00)
      else $error("reserved view not zero");
   a_wait_set: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rxEvt.byteDone |=> waiting_q)
      else $error("byte waiting not set");
   a_wait_clear: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (rdData && !rxEvt.byteDone) |=> !waiting_q && !newFrame_q && !mpBit_q)
      else $error("data read did not clear flags");
   a_mp_hold: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rxEvt.byteDone |=> mpBit_q == $past(rxEvt.mpBit))
      else $error("mp bit not captured");
   a_noise_set: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rxEvt.noiseHit |=> noise_q)
      else $error("noise not flagged");
   a_break_sat: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (brkCnt_q == ums_pkg::BREAK_MAX && rxEvt.breakTick && !rxEvt.breakEnd)
      |=> brkCnt_q == ums_pkg::BREAK_MAX)
      else $error("break count wrapped");
   a_null_clear: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (rxEvt.frameEnd && !rxEvt.nullStart) |=> !nullSt_q)
      else $error("null start not cleared");
   a_hit_set: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rxEvt.slaveHit |=> slvHit_q ##0 (viewSel_q != 3'h5 || mode_status_field[1]))
      else $error("slave hit lost");
   a_view_sel: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (regWr && regAddr == 2'h0) |=> viewSel_q == $past(regWdata[7:5]))
      else $error("selector not written");
   a_dali_view: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      viewSel_q == 3'h4 |-> mode_status_field[4:3] == {waiting_q, collision_q})
      else $error("dali view mismatch");
   a_mode_read: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (regRd && regAddr == ums_pkg::ADDR_MODE)
      |=> regRdata_q == {$past(viewSel_q), $past(mode_status_field)})
      else $error("mode read data wrong");
   a_mp_view: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      viewSel_q == ums_pkg::VIEW_MP
      |-> mode_status_field == {noise_q, 2'h0, newFrame_q, mpBit_q})
      else $error("multiprocessor view wrong");
   a_noise_view: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      viewSel_q == ums_pkg::VIEW_NOISE |-> mode_status_field == {noise_q, 4'h0})
      else $error("noise view wrong");
   a_lin_view: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      viewSel_q == ums_pkg::VIEW_LIN |-> mode_status_field == {noise_q, brkDur_q})
      else $error("break view wrong");
   a_dmx_view: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      viewSel_q == ums_pkg::VIEW_DMX
      |-> mode_status_field == {waiting_q, nullSt_q, nonNullSt_q, slvHit_q,
                       markBreak_q})
      else $error("dmx view wrong");
   a_new_frame: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rxEvt.byteDone |=> newFrame_q == $past(rxEvt.firstOfFrame))
      else $error("new frame not captured");
   a_break_hold: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rxEvt.breakEnd |=> brkDur_q == $past(brkCnt_q) && brkCnt_q == 4'h0)
      else $error("break length not held");
   a_addr_class: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rxEvt.addrValid |=> addrClass_q == ums_pkg::ADDR_SHORT
         || addrClass_q == ums_pkg::ADDR_GROUP
         || addrClass_q == ums_pkg::ADDR_BCAST
         || addrClass_q == ums_pkg::ADDR_SPECIAL)
      else $error("address class code reserved");
   a_collision_flag_set: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rxEvt.collision |=> collision_q)
      else $error("collision not flagged");
   a_nonnull_clear: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (rxEvt.frameEnd && !rxEvt.nonNullStart) |=> !nonNullSt_q)
      else $error("nonnull start not cleared");
   a_mark_follow: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      mbSync_q[1] == mbSync_q[2] |=> markBreak_q == $past(mbSync_q[2]))
      else $error("mark-break not followed");
   a_irq_level: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      irq_q == |(irqStat_q & irqMask_q))
      else $error("interrupt level wrong");
   a_rdata_idle: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !regRd |=> regRdata_q == 8'h00)
      else $error("read data not idle");
endmodule
`default_nettype wire

// [sim/ums_rx_node.sv]
// model: remote serial nodes feeding receiver events into the status view
`timescale 1ns/10ps
`default_nettype none
module ums_rx_node (
   // clock
   input wire logic sys_clk,
   // receiver events toward the block
   output var ums_pkg::ums_rx_type rxEvt,
   // mark-break line condition
   output var logic markBreakPin
);
   // ==========================================
   // idle levels
   initial begin
      rxEvt = '0;
      markBreakPin = 1'b0;
   end
   // ==========================================
   // one-cycle event pulse, launched after an edge
   task automatic fire(input ums_pkg::ums_rx_type e);
      @(posedge sys_clk);
      rxEvt <= e;
      @(posedge sys_clk);
      rxEvt <= '0;
   endtask
   // received byte with frame start and multiprocessor bit
   task automatic byte_in(input logic first, input logic mp);
      ums_pkg::ums_rx_type e;
      e = '0;
      e.byteDone = 1'b1;
      e.byteData = 8'h5A;
      e.firstOfFrame = first;
      e.mpBit = mp;
      fire(e);
   endtask
   // filter sample mismatch seen
   task automatic noise();
      ums_pkg::ums_rx_type e;
      e = '0;
      e.noiseHit = 1'b1;
      fire(e);
   endtask
   // break of n bit times, then its end
   task automatic brk(input int n);
      ums_pkg::ums_rx_type e;
      e = '0;
      e.breakTick = 1'b1;
      repeat (n) fire(e);
      e = '0;
      e.breakEnd = 1'b1;
      fire(e);
   endtask
   // dali byte with collision and address class
   task automatic dali(input logic [2:0] code);
      ums_pkg::ums_rx_type e;
      e = '0;
      e.byteDone = 1'b1;
      e.collision = 1'b1;
      e.addrValid = 1'b1;
      e.addrCode = code;
      fire(e);
   endtask
   // dmx start code and slave match detection
   task automatic dmx(input logic nul, input logic nonNul, input logic hit);
      ums_pkg::ums_rx_type e;
      e = '0;
      e.nullStart = nul;
      e.nonNullStart = nonNul;
      e.slaveHit = hit;
      fire(e);
   endtask
   // frame reception over
   task automatic frame_end();
      ums_pkg::ums_rx_type e;
      e = '0;
      e.frameEnd = 1'b1;
      fire(e);
   endtask
   // line condition level, changed after an edge
   task automatic mark(input logic v);
      @(posedge sys_clk);
      markBreakPin <= v;
   endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// testbench: register-level checks of the uart mode status view
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic sys_clk; // system clock
   logic resetn; // sync reset, active low
   logic [1:0] regAddr; // register index
   logic [7:0] regWdata; // write data
   logic regWr; // write strobe
   logic regRd; // read strobe
   logic [7:0] regRdata; // read data
   logic irq; // interrupt level
   ums_pkg::ums_rx_type rxEvt; // receiver events
   logic markBreakPin; // line condition
   int fail_count; // mismatches
   int n_compared; // comparisons
   logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h3}; // sent
   logic [2:0] expCodes [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h5}; // read
   // ==========================================
   // design and far-side model
   ums_mode_status dut (.sys_clk(sys_clk), .resetn(resetn),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .rxEvt(rxEvt),
      .markBreakPin(markBreakPin), .irq(irq));
   ums_rx_node node (.sys_clk(sys_clk), .rxEvt(rxEvt),
      .markBreakPin(markBreakPin));
   // ==========================================
   // clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // compare and report
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one-cycle write
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask
   // one-cycle read, data checked under mask in the cycle after
   task automatic rd(input logic [1:0] a, input logic [7:0] exp,
                     input logic [7:0] m);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      if (m != 8'h00) begin
         chk(regRdata & m, exp);
      end
   endtask
   // interrupt level after it has settled
   task automatic chk_irq(input logic exp);
      repeat (2) @(posedge sys_clk);
      #1;
      chk({7'h00, irq}, {7'h00, exp});
   endtask
   // verdict
   task automatic end_sim();
      $display("compared %0d, failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      end_sim();
   end
   // ==========================================
   // main sequence
   initial begin
      resetn = 1'b0;
      regAddr = 2'h0;
      regWdata = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      fail_count = 0;
      n_compared = 0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      rd(ums_pkg::ADDR_MODE, 8'h00, 8'hFF);
      wr(ums_pkg::ADDR_MODE, 8'hFF);
      rd(ums_pkg::ADDR_MODE, 8'hE0, 8'hFF);
      wr(ums_pkg::ADDR_MODE, 8'h1F);
      node.byte_in(1'b1, 1'b1);
      rd(ums_pkg::ADDR_MODE, 8'h03, 8'hFF);
      rd(ums_pkg::ADDR_RXDATA, 8'h5A, 8'hFF);
      rd(ums_pkg::ADDR_MODE, 8'h00, 8'hFF);
      node.byte_in(1'b0, 1'b1);
      rd(ums_pkg::ADDR_MODE, 8'h01, 8'hFF);
      rd(ums_pkg::ADDR_RXDATA, 8'h5A, 8'hFF);
      node.noise();
      rd(ums_pkg::ADDR_MODE, 8'h10, 8'hFF);
      wr(ums_pkg::ADDR_MODE, 8'h20);
      rd(ums_pkg::ADDR_MODE, 8'h30, 8'hFF);
      wr(ums_pkg::ADDR_MODE, 8'h60);
      rd(ums_pkg::ADDR_MODE, 8'h60, 8'hFF);
      wr(ums_pkg::ADDR_MODE, 8'hC0);
      rd(ums_pkg::ADDR_MODE, 8'hC0, 8'hFF);
      wr(ums_pkg::ADDR_MODE, 8'h40);
      node.brk(5);
      rd(ums_pkg::ADDR_MODE, 8'h55, 8'hFF);
      node.brk(20);
      rd(ums_pkg::ADDR_MODE, 8'h5F, 8'hFF);
      rd(ums_pkg::ADDR_RXDATA, 8'h5A, 8'hFF);
      rd(ums_pkg::ADDR_MODE, 8'h4F, 8'hFF);
      wr(ums_pkg::ADDR_MODE, 8'h80);
      for (int i = 0; i < 5; i++) begin
         node.dali(codes[i]);
         rd(ums_pkg::ADDR_MODE, {5'h13, expCodes[i]}, 8'hFF);
         rd(ums_pkg::ADDR_RXDATA, 8'h00, 8'hFF);
         rd(ums_pkg::ADDR_MODE, 8'h80, 8'hF8);
      end
      wr(ums_pkg::ADDR_MODE, 8'hA0);
      node.dmx(1'b1, 1'b0, 1'b1);
      rd(ums_pkg::ADDR_MODE, 8'hAA, 8'hFF);
      node.frame_end();
      rd(ums_pkg::ADDR_MODE, 8'hA0, 8'hFF);
      node.dmx(1'b0, 1'b1, 1'b0);
      rd(ums_pkg::ADDR_MODE, 8'hA4, 8'hFF);
      node.frame_end();
      rd(ums_pkg::ADDR_MODE, 8'hA0, 8'hFF);
      node.mark(1'b1);
      repeat (6) @(posedge sys_clk);
      rd(ums_pkg::ADDR_MODE, 8'hA1, 8'hFF);
      node.mark(1'b0);
      repeat (6) @(posedge sys_clk);
      rd(ums_pkg::ADDR_MODE, 8'hA0, 8'hFF);
      node.byte_in(1'b0, 1'b0);
      rd(ums_pkg::ADDR_MODE, 8'hB0, 8'hFF);
      rd(ums_pkg::ADDR_IRQ_STAT, 8'h1F, 8'h1F);
      chk_irq(1'b0);
      wr(ums_pkg::ADDR_IRQ_MASK, 8'h02);
      rd(ums_pkg::ADDR_IRQ_MASK, 8'h02, 8'h1F);
      node.noise();
      chk_irq(1'b1);
      rd(ums_pkg::ADDR_IRQ_STAT, 8'h02, 8'h1F);
      chk_irq(1'b0);
      wr(ums_pkg::ADDR_IRQ_MASK, 8'h00);
      node.noise();
      chk_irq(1'b0);
      wr(ums_pkg::ADDR_IRQ_MASK, 8'h02);
      chk_irq(1'b1);
      wr(ums_pkg::ADDR_IRQ_STAT, 8'hFF);
      rd(ums_pkg::ADDR_IRQ_STAT, 8'h02, 8'h1F);
      rd(ums_pkg::ADDR_IRQ_STAT, 8'h00, 8'h1F);
      end_sim();
   end
endmodule
`default_nettype wire
